// file: inc/imhpd_pkg.sv
// constants and types shared by both ends of the isa-mode host port
// Operation
// - isa mode only with both straps unpulled
// - data via port offset 10h or window
// - addresses 800h to FFFh hit data port
// - window decoded only from address bit 11
// - single reads and writes on both routes
// - host bursts only through the window
// - burst read returns consecutive data words
// - read of 1Fh resets, write only stores
// - big-endian host swaps lanes in wiring
package imhpd_pkg;
   // ---------------------------------------------------------------
   // bus geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W     = 12;
   localparam int DATA_W     = 16;
   localparam int LANE_W     = 8;
   localparam int OFF_W      = 5;
   localparam int WIN_BIT    = 11;
   localparam int OFF_LSB    = 1;
   localparam int OFF_MSB    = 5;
   localparam int GAP_LSB    = 6;
   localparam int GAP_MSB    = 10;
   localparam int CSR_NUM    = 32;
   // ---------------------------------------------------------------
   // offsets and reset values
   // ---------------------------------------------------------------
   localparam logic [4:0]  OFF_DATA_PORT = 5'h10;
   localparam logic [4:0]  OFF_UNUSED    = 5'h11;
   localparam logic [4:0]  OFF_NO_HIGH   = 5'h1E;
   localparam logic [4:0]  OFF_RESET     = 5'h1F;
   localparam logic [7:0]  CSR_RST       = 8'h00;
   localparam logic [15:0] IDLE_DATA     = 16'h0000;
   localparam logic [15:0] BUS_PULL      = 16'hFFFF;
   // ---------------------------------------------------------------
   // sizes and timing counts
   // ---------------------------------------------------------------
   localparam int FIFO_DEPTH  = 8;
   localparam int STROBE_CYC  = 10;
   localparam int STRAP_WAIT  = 3;
   localparam int LEN_W       = 4;
   // ---------------------------------------------------------------
   // state machines
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      DEV_IDLE = 2'h0,
      DEV_ACT  = 2'h1,
      DEV_HOLD = 2'h3
   } imhpd_dev_st_t;
   typedef enum logic [1:0] {
      HST_IDLE    = 2'h0,
      HST_SETUP   = 2'h1,
      HST_STROBE  = 2'h3,
      HST_RECOVER = 2'h2
   } imhpd_host_st_t;
endpackage

// file: inc/imhpd_bus_if.sv
// host bus pins between the host end and the device end
`timescale 1ns/1ps
`default_nettype none
interface imhpd_bus_if;
   logic [11:0] addr;
   logic        cs_n;
   logic        rd_n;
   logic        wr_n;
   logic [15:0] hdq_o;
   logic        hdq_oe_n;
   logic [15:0] ddq_o;
   logic        ddq_oe_n;
   logic        select_pull;
   logic        clock_pull;
   logic [15:0] dq;
   // shared data wire; pull-ups win when nobody drives
   assign dq = !ddq_oe_n ? ddq_o :
               (!hdq_oe_n ? hdq_o : imhpd_pkg::BUS_PULL);
   modport host (output addr, output cs_n, output rd_n, output wr_n,
                 output hdq_o, output hdq_oe_n, output select_pull,
                 output clock_pull, input dq);
   modport dev  (input addr, input cs_n, input rd_n, input wr_n,
                 output ddq_o, output ddq_oe_n, input select_pull,
                 input clock_pull, input dq);
endinterface
`default_nettype wire

// file: design/imhpd_device_end.sv
// device end: pin decode, csr file, packet data port and receive fifo
`timescale 1ns/1ps
`default_nettype none
module imhpd_fifo #(
   parameter int W = 16,
   parameter int D = 8
) (
   input  wire logic         i_core_clk,
   input  wire logic         i_rst,
   input  wire logic         i_clr,
   input  wire logic         i_in_valid,
   output logic              o_in_ready,
   input  wire logic [W-1:0] i_in_data,
   output logic              o_out_valid,
   input  wire logic         i_out_ready,
   output logic [W-1:0]      o_out_data
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   logic [W-1:0]  mem_r [D];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0]   cnt_r, cnt_nxt;
   logic          push, pop;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(D - 1)) ? '0 : p + 1'b1;
   endfunction

   assign o_in_ready  = (cnt_r != (AW + 1)'(D));
   assign o_out_valid = (cnt_r != '0);
   assign o_out_data  = mem_r[rp_r];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   always_comb begin
      wp_nxt  = push ? bump(wp_r) : wp_r;
      rp_nxt  = pop ? bump(rp_r) : rp_r;
      cnt_nxt = cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
      if (i_clr) begin
         wp_nxt  = '0;
         rp_nxt  = '0;
         cnt_nxt = '0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         wp_r  <= wp_nxt;
         rp_r  <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // storage needs no reset; empty flag guards every read
   always_ff @(posedge i_core_clk) begin
      if (push) begin
         mem_r[wp_r] <= i_in_data;
      end
   end
endmodule

module imhpd_device_end #(
   parameter int DEPTH = imhpd_pkg::FIFO_DEPTH
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   imhpd_bus_if.dev         bus,
   input  wire logic        i_rx_valid,
   output logic             o_rx_ready,
   input  wire logic [15:0] i_rx_data,
   output logic             o_tx_valid,
   output logic [15:0]      o_tx_data,
   output logic             o_csr_wr,
   output logic [4:0]       o_csr_off,
   output logic [7:0]       o_csr_wdata,
   output logic             o_isa_mode,
   output logic             o_soft_reset
);
   // pin vector: straps, strobes, address, data
   localparam int PV_W = 2 + 3 + imhpd_pkg::ADDR_W + imhpd_pkg::DATA_W;

   imhpd_pkg::imhpd_dev_st_t st_r, st_nxt;
   logic [PV_W-1:0] pin_s1_r, pin_s2_r;
   logic [1:0]      strap_s;
   logic            cs_n_s, rd_n_s, wr_n_s;
   logic [11:0]     addr_s;
   logic [15:0]     dq_s;
   logic [1:0]      cap_cnt_r, cap_cnt_nxt;
   logic            isa_r, isa_nxt;
   logic [7:0]      csr_r [imhpd_pkg::CSR_NUM];
   logic [7:0]      csr_nxt [imhpd_pkg::CSR_NUM];
   logic [15:0]     ddq_r, ddq_nxt;
   logic            oe_n_r, oe_n_nxt;
   logic            txv_r, txv_nxt, csrw_r, csrw_nxt, srst_r, srst_nxt;
   logic [15:0]     txd_r, txd_nxt;
   logic [4:0]      csro_r, csro_nxt;
   logic [7:0]      csrd_r, csrd_nxt;
   logic            f_valid, f_pop;
   logic [15:0]     f_data;
   logic            rd_act, wr_act, in_win, in_csr, to_port;
   logic [4:0]      off;

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   function automatic logic [4:0] csr_off(input logic [11:0] a);
      csr_off = a[imhpd_pkg::OFF_MSB:imhpd_pkg::OFF_LSB];
   endfunction

   function automatic logic csr_space(input logic [11:0] a);
      csr_space = !a[imhpd_pkg::WIN_BIT] &&
                  (a[imhpd_pkg::GAP_MSB:imhpd_pkg::GAP_LSB] == '0);
   endfunction

   assign {strap_s, cs_n_s, rd_n_s, wr_n_s, addr_s, dq_s} = pin_s2_r;
   assign rd_act  = !cs_n_s && !rd_n_s;
   assign wr_act  = !cs_n_s && !wr_n_s;
   assign in_win  = addr_s[imhpd_pkg::WIN_BIT];
   // gap 40h-7FFh and offset 11h ignored
   assign in_csr  = csr_space(addr_s) && off != imhpd_pkg::OFF_UNUSED;
   assign off     = csr_off(addr_s);
   assign to_port = in_win || (in_csr && off == imhpd_pkg::OFF_DATA_PORT);

   // ---------------------------------------------------------------
   // receive fifo
   // ---------------------------------------------------------------
   imhpd_fifo #(.W(imhpd_pkg::DATA_W), .D(DEPTH)) u_rx_fifo (
      .i_core_clk  (i_core_clk),
      .i_rst       (i_rst),
      .i_clr       (srst_r),
      .i_in_valid  (i_rx_valid),
      .o_in_ready  (o_rx_ready),
      .i_in_data   (i_rx_data),
      .o_out_valid (f_valid),
      .i_out_ready (f_pop),
      .o_out_data  (f_data)
   );

   // ---------------------------------------------------------------
   // access sequencer
   // ---------------------------------------------------------------
   always_comb begin
      st_nxt      = st_r;
      cap_cnt_nxt = cap_cnt_r;
      isa_nxt     = isa_r;
      csr_nxt     = csr_r;
      ddq_nxt     = ddq_r;
      oe_n_nxt    = oe_n_r;
      txv_nxt     = 1'b0;
      txd_nxt     = txd_r;
      csrw_nxt    = 1'b0;
      csro_nxt    = csro_r;
      csrd_nxt    = csrd_r;
      srst_nxt    = 1'b0;
      f_pop       = 1'b0;
      // both straps low means isa mode
      if (cap_cnt_r != 2'(imhpd_pkg::STRAP_WAIT)) begin
         cap_cnt_nxt = cap_cnt_r + 1'b1;
      end else if (cap_cnt_r == 2'(imhpd_pkg::STRAP_WAIT) && !isa_r &&
                   st_r == imhpd_pkg::DEV_IDLE && !rd_act && !wr_act &&
                   cap_cnt_r[0]) begin
         isa_nxt = (strap_s == 2'h0);
      end
      case (st_r)
         imhpd_pkg::DEV_IDLE: begin
            if (isa_r && (rd_act || wr_act)) begin
               st_nxt = imhpd_pkg::DEV_ACT;
            end
         end
         imhpd_pkg::DEV_ACT: begin
            st_nxt = imhpd_pkg::DEV_HOLD;
            if (rd_act && (in_win || in_csr)) begin
               oe_n_nxt = 1'b0;
               ddq_nxt  = imhpd_pkg::IDLE_DATA;
               if (to_port) begin
                  // each read pops the next word
                  f_pop = f_valid;
                  if (f_valid) begin
                     ddq_nxt = f_data;
                  end
               end else if (off == imhpd_pkg::OFF_RESET) begin
                  srst_nxt = 1'b1;
               end else if (off != imhpd_pkg::OFF_UNUSED) begin
                  ddq_nxt[7:0] = csr_r[off];
                  if (off != imhpd_pkg::OFF_NO_HIGH) begin
                     ddq_nxt[15:8] = csr_r[off | 5'h01];
                  end
               end
            end else if (wr_act && to_port) begin
               txv_nxt = 1'b1;
               txd_nxt = dq_s;
            end else if (wr_act && in_csr &&
                         off != imhpd_pkg::OFF_UNUSED) begin
               // low lane stored, no reset on 1Fh
               csr_nxt[off] = dq_s[7:0];
               csrw_nxt     = 1'b1;
               csro_nxt     = off;
               csrd_nxt     = dq_s[7:0];
            end
         end
         imhpd_pkg::DEV_HOLD: begin
            if (!rd_act && !wr_act) begin
               st_nxt   = imhpd_pkg::DEV_IDLE;
               oe_n_nxt = 1'b1;
            end
         end
         default: begin
            st_nxt   = imhpd_pkg::DEV_IDLE;
            oe_n_nxt = 1'b1;
         end
      endcase
      if (srst_r) begin
         for (int i = 0; i < imhpd_pkg::CSR_NUM; i++) begin
            csr_nxt[i] = imhpd_pkg::CSR_RST;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         pin_s1_r  <= '1;
         pin_s2_r  <= '1;
         st_r      <= imhpd_pkg::DEV_IDLE;
         cap_cnt_r <= 2'h0;
         isa_r     <= 1'b0;
         ddq_r     <= imhpd_pkg::IDLE_DATA;
         oe_n_r    <= 1'b1;
         txv_r     <= 1'b0;
         txd_r     <= imhpd_pkg::IDLE_DATA;
         csrw_r    <= 1'b0;
         csro_r    <= 5'h00;
         csrd_r    <= imhpd_pkg::CSR_RST;
         srst_r    <= 1'b0;
         for (int i = 0; i < imhpd_pkg::CSR_NUM; i++) begin
            csr_r[i] <= imhpd_pkg::CSR_RST;
         end
      end else begin
         pin_s1_r  <= {bus.select_pull, bus.clock_pull, bus.cs_n,
                       bus.rd_n, bus.wr_n, bus.addr, bus.dq};
         pin_s2_r  <= pin_s1_r;
         st_r      <= st_nxt;
         cap_cnt_r <= cap_cnt_nxt;
         isa_r     <= isa_nxt;
         ddq_r     <= ddq_nxt;
         oe_n_r    <= oe_n_nxt;
         txv_r     <= txv_nxt;
         txd_r     <= txd_nxt;
         csrw_r    <= csrw_nxt;
         csro_r    <= csro_nxt;
         csrd_r    <= csrd_nxt;
         srst_r    <= srst_nxt;
         csr_r     <= csr_nxt;
      end
   end

   assign bus.ddq_o    = ddq_r;
   assign bus.ddq_oe_n = oe_n_r;
   assign o_tx_valid   = txv_r;
   assign o_tx_data    = txd_r;
   assign o_csr_wr     = csrw_r;
   assign o_csr_off    = csro_r;
   assign o_csr_wdata  = csrd_r;
   assign o_isa_mode   = isa_r;
   assign o_soft_reset = srst_r;
endmodule
`default_nettype wire

// file: design/imhpd_host_end.sv
// host end: strobe sequencer driving single and burst bus cycles
`timescale 1ns/1ps
`default_nettype none
module imhpd_host_end #(
   parameter int STROBE_CYC = imhpd_pkg::STROBE_CYC,
   parameter bit BIG_ENDIAN = 1'b0
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   imhpd_bus_if.host        bus,
   input  wire logic        i_req,
   input  wire logic        i_wr,
   input  wire logic        i_burst,
   input  wire logic [3:0]  i_len,
   input  wire logic [11:0] i_addr,
   input  wire logic [15:0] i_wdata,
   output logic             o_ready,
   output logic             o_rvalid,
   output logic [15:0]      o_rdata,
   output logic             o_done,
   output logic             o_refused
);
   imhpd_pkg::imhpd_host_st_t st_r, st_nxt;
   logic [15:0] dq_s1_r, dq_s2_r;
   logic [11:0] addr_r, addr_nxt;
   logic [15:0] wd_r, wd_nxt, rd_r, rd_nxt;
   logic        wr_r, wr_nxt;
   logic [3:0]  left_r, left_nxt;
   logic [7:0]  cnt_r, cnt_nxt;
   logic        cs_n_r, cs_n_nxt, rdn_r, rdn_nxt, wrn_r, wrn_nxt;
   logic        oe_n_r, oe_n_nxt;
   logic        rv_r, rv_nxt, dn_r, dn_nxt, rf_r, rf_nxt;

   // big-endian lane swap sits in the host wiring
   function automatic logic [15:0] lanes(input logic [15:0] w);
      lanes = BIG_ENDIAN ? {w[7:0], w[15:8]} : w;
   endfunction

   always_comb begin
      st_nxt   = st_r;
      addr_nxt = addr_r;
      wd_nxt   = wd_r;
      rd_nxt   = rd_r;
      wr_nxt   = wr_r;
      left_nxt = left_r;
      cnt_nxt  = cnt_r;
      cs_n_nxt = cs_n_r;
      rdn_nxt  = rdn_r;
      wrn_nxt  = wrn_r;
      oe_n_nxt = oe_n_r;
      rv_nxt   = 1'b0;
      dn_nxt   = 1'b0;
      rf_nxt   = 1'b0;
      case (st_r)
         imhpd_pkg::HST_IDLE: begin
            if (i_req) begin
               // bursts outside the window are refused
               if (i_burst && !i_addr[imhpd_pkg::WIN_BIT]) begin
                  rf_nxt = 1'b1;
               end else begin
                  st_nxt   = imhpd_pkg::HST_SETUP;
                  addr_nxt = i_addr;
                  wd_nxt   = i_wdata;
                  wr_nxt   = i_wr;
                  left_nxt = (i_burst && i_len != 4'h0) ?
                             i_len - 1'b1 : 4'h0;
                  cs_n_nxt = 1'b0;
                  oe_n_nxt = !i_wr;
               end
            end
         end
         imhpd_pkg::HST_SETUP: begin
            st_nxt  = imhpd_pkg::HST_STROBE;
            cnt_nxt = 8'h00;
            rdn_nxt = wr_r;
            wrn_nxt = !wr_r;
         end
         imhpd_pkg::HST_STROBE: begin
            cnt_nxt = cnt_r + 1'b1;
            // strobe is long enough to cover both synchronisers
            if (cnt_r == 8'(STROBE_CYC - 1)) begin
               st_nxt  = imhpd_pkg::HST_RECOVER;
               rdn_nxt = 1'b1;
               wrn_nxt = 1'b1;
               if (!wr_r) begin
                  rd_nxt = lanes(dq_s2_r);
                  rv_nxt = 1'b1;
               end
            end
         end
         imhpd_pkg::HST_RECOVER: begin
            if (left_r != 4'h0) begin
               // next word, address stays inside the window
               st_nxt   = imhpd_pkg::HST_SETUP;
               left_nxt = left_r - 1'b1;
               addr_nxt = {addr_r[11], addr_r[10:1] + 1'b1, 1'b0};
            end else begin
               st_nxt   = imhpd_pkg::HST_IDLE;
               cs_n_nxt = 1'b1;
               oe_n_nxt = 1'b1;
               dn_nxt   = 1'b1;
            end
         end
         default: begin
            st_nxt   = imhpd_pkg::HST_IDLE;
            cs_n_nxt = 1'b1;
            rdn_nxt  = 1'b1;
            wrn_nxt  = 1'b1;
            oe_n_nxt = 1'b1;
         end
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         st_r    <= imhpd_pkg::HST_IDLE;
         dq_s1_r <= imhpd_pkg::BUS_PULL;
         dq_s2_r <= imhpd_pkg::BUS_PULL;
         addr_r  <= 12'h000;
         wd_r    <= imhpd_pkg::IDLE_DATA;
         rd_r    <= imhpd_pkg::IDLE_DATA;
         wr_r    <= 1'b0;
         left_r  <= 4'h0;
         cnt_r   <= 8'h00;
         cs_n_r  <= 1'b1;
         rdn_r   <= 1'b1;
         wrn_r   <= 1'b1;
         oe_n_r  <= 1'b1;
         rv_r    <= 1'b0;
         dn_r    <= 1'b0;
         rf_r    <= 1'b0;
      end else begin
         st_r    <= st_nxt;
         dq_s1_r <= bus.dq;
         dq_s2_r <= dq_s1_r;
         addr_r  <= addr_nxt;
         wd_r    <= wd_nxt;
         rd_r    <= rd_nxt;
         wr_r    <= wr_nxt;
         left_r  <= left_nxt;
         cnt_r   <= cnt_nxt;
         cs_n_r  <= cs_n_nxt;
         rdn_r   <= rdn_nxt;
         wrn_r   <= wrn_nxt;
         oe_n_r  <= oe_n_nxt;
         rv_r    <= rv_nxt;
         dn_r    <= dn_nxt;
         rf_r    <= rf_nxt;
      end
   end

   assign bus.addr     = addr_r;
   assign bus.cs_n     = cs_n_r;
   assign bus.rd_n     = rdn_r;
   assign bus.wr_n     = wrn_r;
   assign bus.hdq_o    = lanes(wd_r);
   assign bus.hdq_oe_n = oe_n_r;
   // board leaves both straps without pull-ups
   assign bus.select_pull = 1'b0;
   assign bus.clock_pull  = 1'b0;
   assign o_ready   = (st_r == imhpd_pkg::HST_IDLE);
   assign o_rvalid  = rv_r;
   assign o_rdata   = rd_r;
   assign o_done    = dn_r;
   assign o_refused = rf_r;
endmodule
`default_nettype wire

// file: test/imhpd_bus_sva.sv
// concurrent checks on the host bus between the two ends
`timescale 1ns/1ps
`default_nettype none
module imhpd_bus_sva (
   input wire logic        i_core_clk,
   input wire logic        i_rst,
   input wire logic [11:0] addr,
   input wire logic        cs_n,
   input wire logic        rd_n,
   input wire logic        wr_n,
   input wire logic [15:0] hdq_o,
   input wire logic        hdq_oe_n,
   input wire logic [15:0] ddq_o,
   input wire logic        ddq_oe_n,
   input wire logic        select_pull,
   input wire logic        clock_pull,
   input wire logic [15:0] dq
);
   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   logic hit;
   assign hit = addr[11] || (addr[10:6] == 5'h00 && addr[5:1] != 5'h11);

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   sequence s_rd_fall;
      $fell(rd_n) && !cs_n;
   endsequence
   sequence s_rd_pulse;
      ##9 !rd_n ##1 rd_n;
   endsequence

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   property p_straps;
      !select_pull && !clock_pull;
   endproperty
   a_straps: assert property (p_straps)
      else $error("strap pulled while isa mode expected");

   property p_hit_drive;
      s_rd_fall ##0 hit |-> ##4 !ddq_oe_n;
   endproperty
   a_hit_drive: assert property (p_hit_drive)
      else $error("device did not answer a decoded read");

   property p_gap_quiet;
      s_rd_fall and !hit |-> ##2 ddq_oe_n [*6];
   endproperty
   a_gap_quiet: assert property (p_gap_quiet)
      else $error("device drove an unused address");

   property p_release;
      !ddq_oe_n |-> !rd_n || !$past(rd_n) || !$past(rd_n, 2) ||
                    !$past(rd_n, 3) || !$past(rd_n, 4) || !$past(rd_n, 5);
   endproperty
   a_release: assert property (p_release)
      else $error("device drove bus long after read strobe");

   property p_no_fight;
      !(!ddq_oe_n && !hdq_oe_n);
   endproperty
   a_no_fight: assert property (p_no_fight)
      else $error("both ends drive the data bus");

   property p_dout_stable;
      !ddq_oe_n && !$past(ddq_oe_n) |-> $stable(ddq_o) && dq == ddq_o;
   endproperty
   a_dout_stable: assert property (p_dout_stable)
      else $error("read data moved while driven");

   property p_rd_width;
      s_rd_fall |-> s_rd_pulse;
   endproperty
   a_rd_width: assert property (p_rd_width)
      else $error("read strobe width wrong");

   property p_setup;
      $fell(cs_n) |-> rd_n && wr_n ##1 (!rd_n || !wr_n);
   endproperty
   a_setup: assert property (p_setup)
      else $error("strobe not one cycle after select");

   property p_addr_hold;
      (!rd_n || !wr_n) && !cs_n && !($past(rd_n) && $past(wr_n)) |->
         $stable(addr);
   endproperty
   a_addr_hold: assert property (p_addr_hold)
      else $error("address moved during strobe");

   property p_wr_drive;
      !wr_n |-> !hdq_oe_n && !cs_n && rd_n && dq == hdq_o;
   endproperty
   a_wr_drive: assert property (p_wr_drive)
      else $error("write strobe without host data or select");
endmodule
`default_nettype wire

// file: test/imhpd_tb.sv
// self-checking bench: host end and device end joined by the bus
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(16'(g), 16'(e))
module imhpd_tb;
   logic        i_core_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic        i_req = 1'b0, i_wr = 1'b0, i_burst = 1'b0;
   logic [3:0]  i_len = 4'h1;
   logic [11:0] i_addr = 12'h000;
   logic [15:0] i_wdata = 16'h0000, i_rx_data = 16'h0000;
   logic        i_rx_valid = 1'b0;
   logic        o_ready, o_rvalid, o_done, o_refused, o_rx_ready;
   logic        o_tx_valid, o_csr_wr, o_isa_mode, o_soft_reset;
   logic [15:0] o_rdata, o_tx_data;
   logic [4:0]  o_csr_off;
   logic [7:0]  o_csr_wdata, ecsr [32];
   logic [15:0] rq [$], tq [$], eq [$], d;
   logic [12:0] lcw;
   integer      seed = 32'h76ABB008;
   int          mismatches = 0, n_checks = 0, cyc = 0;
   int          n_done = 0, n_ref = 0, n_rst = 0, n_cw = 0, nw, nt, nr;

   always #4 i_core_clk = ~i_core_clk;
   // ---------------------------------------------------------------
   // the two ends and the bus checker
   // ---------------------------------------------------------------
   imhpd_bus_if imhpd_bus_if_i ();
   imhpd_host_end imhpd_host_end_i (.i_core_clk(i_core_clk),
      .i_rst(i_rst), .bus(imhpd_bus_if_i), .i_req(i_req), .i_wr(i_wr),
      .i_burst(i_burst), .i_len(i_len), .i_addr(i_addr),
      .i_wdata(i_wdata), .o_ready(o_ready), .o_rvalid(o_rvalid),
      .o_rdata(o_rdata), .o_done(o_done), .o_refused(o_refused));
   imhpd_device_end imhpd_device_end_i (.i_core_clk(i_core_clk),
      .i_rst(i_rst), .bus(imhpd_bus_if_i), .i_rx_valid(i_rx_valid),
      .o_rx_ready(o_rx_ready), .i_rx_data(i_rx_data),
      .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
      .o_csr_wr(o_csr_wr), .o_csr_off(o_csr_off),
      .o_csr_wdata(o_csr_wdata), .o_isa_mode(o_isa_mode),
      .o_soft_reset(o_soft_reset));
   imhpd_bus_sva imhpd_bus_sva_i (.i_core_clk(i_core_clk), .i_rst(i_rst),
      .addr(imhpd_bus_if_i.addr), .cs_n(imhpd_bus_if_i.cs_n),
      .rd_n(imhpd_bus_if_i.rd_n), .wr_n(imhpd_bus_if_i.wr_n),
      .hdq_o(imhpd_bus_if_i.hdq_o), .hdq_oe_n(imhpd_bus_if_i.hdq_oe_n),
      .ddq_o(imhpd_bus_if_i.ddq_o), .ddq_oe_n(imhpd_bus_if_i.ddq_oe_n),
      .select_pull(imhpd_bus_if_i.select_pull),
      .clock_pull(imhpd_bus_if_i.clock_pull), .dq(imhpd_bus_if_i.dq));
   // ---------------------------------------------------------------
   // monitors, timeout and helpers
   // ---------------------------------------------------------------
   always @(posedge i_core_clk) begin
      cyc++;
      if (o_rvalid === 1'b1) rq.push_back(o_rdata);
      if (o_tx_valid === 1'b1) tq.push_back(o_tx_data);
      if (o_done === 1'b1) n_done++;
      if (o_refused === 1'b1) n_ref++;
      if (o_soft_reset === 1'b1) n_rst++;
      if (o_csr_wr === 1'b1) begin
         n_cw++;
         lcw = {o_csr_off, o_csr_wdata};
      end
      // bench should finish in under two thousand cycles
      if (cyc == 8000) begin
         mismatches++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // an empty queue yields unknowns so a missing word never matches
   function automatic logic [15:0] pop_r();
      return (rq.size() == 0) ? 16'hXXXX : rq.pop_front();
   endfunction
   function automatic logic [15:0] pop_t();
      return (tq.size() == 0) ? 16'hXXXX : tq.pop_front();
   endfunction
   function automatic logic [15:0] exp_rd(input int o);
      return {(o == 30) ? 8'h00 : ecsr[o | 1], ecsr[o]};
   endfunction

   task automatic xfer(input logic w, input logic b, input logic [3:0] n,
                       input logic [11:0] a, input logic [15:0] v);
      int k;
      int c0;
      k = 0;
      // one budget covers the wait for idle and the transfer itself
      while (o_ready !== 1'b1 && k < 400) begin
         @(negedge i_core_clk);
         k++;
      end
      c0 = n_done + n_ref;
      i_req = 1'b1;
      i_wr = w;
      i_burst = b;
      i_len = n;
      i_addr = a;
      i_wdata = v;
      @(negedge i_core_clk);
      i_req = 1'b0;
      while (n_done + n_ref == c0 && k < 400) begin
         @(negedge i_core_clk);
         k++;
      end
      if (k >= 400) begin
         mismatches++;
         finish_test();
      end
   endtask

   task automatic push_rx(input int cnt);
      for (int i = 0; i < cnt; i++) begin
         @(negedge i_core_clk);
         i_rx_valid = 1'b1;
         i_rx_data = 16'($random(seed));
         #1;
         if (o_rx_ready === 1'b1) eq.push_back(i_rx_data);
      end
      @(negedge i_core_clk);
      i_rx_valid = 1'b0;
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      for (int o = 0; o < 32; o++) ecsr[o] = 8'h00;
      repeat (5) @(negedge i_core_clk);
      i_rst = 1'b0;
      repeat (12) @(negedge i_core_clk);
      `CHK(o_isa_mode, 1'b1);
      for (int o = 0; o < 31; o++) begin
         if (o == 16 || o == 17) continue;
         d = 16'($random(seed));
         nw = n_cw;
         xfer(1'b1, 1'b0, 4'h1, 12'(o * 2), d);
         `CHK(n_cw - nw, 1);
         `CHK(lcw, {5'(o), d[7:0]});
         ecsr[o] = d[7:0];
      end
      for (int o = 0; o < 31; o++) begin
         if (o == 16 || o == 17) continue;
         xfer(1'b0, 1'b0, 4'h1, 12'(o * 2), 16'h0000);
         `CHK(pop_r(), exp_rd(o));
      end
      for (int i = 0; i < 4; i++) begin
         d = (i == 0) ? 16'h0022 : (i == 1) ? 16'h0040 : (i == 2) ?
             16'h07FE : (16'h0040 | (16'($random(seed)) & 16'h07FE));
         nw = n_cw;
         nt = tq.size();
         xfer(1'b0, 1'b0, 4'h1, d[11:0], 16'h0000);
         `CHK(pop_r(), 16'hFFFF);
         xfer(1'b1, 1'b0, 4'h1, d[11:0], 16'h1234);
         `CHK(n_cw - nw + tq.size() - nt, 0);
      end
      push_rx(9);
      `CHK(eq.size(), 8);
      xfer(1'b0, 1'b0, 4'h1, 12'h020, 16'h0000);
      `CHK(pop_r(), eq.pop_front());
      d = 16'h0800 | (16'($random(seed)) & 16'h07FE);
      xfer(1'b0, 1'b0, 4'h1, d[11:0], 16'h0000);
      `CHK(pop_r(), eq.pop_front());
      xfer(1'b0, 1'b1, 4'h6, 12'hFFC, 16'h0000);
      for (int i = 0; i < 6; i++) `CHK(pop_r(), eq.pop_front());
      xfer(1'b0, 1'b0, 4'h1, 12'h020, 16'h0000);
      `CHK(pop_r(), 16'h0000);
      d = 16'($random(seed));
      xfer(1'b1, 1'b0, 4'h1, 12'h020, d);
      `CHK(pop_t(), d);
      xfer(1'b1, 1'b0, 4'h1, 12'hA46, ~d);
      `CHK(pop_t(), ~d);
      xfer(1'b1, 1'b1, 4'h4, 12'hFF8, d ^ 16'h5A5A);
      for (int i = 0; i < 4; i++) `CHK(pop_t(), d ^ 16'h5A5A);
      nr = n_ref;
      xfer(1'b0, 1'b1, 4'h3, 12'h020, 16'h0000);
      xfer(1'b1, 1'b1, 4'h2, 12'h7F0, d);
      `CHK(n_ref - nr, 2);
      `CHK(rq.size() + tq.size(), 0);
      nr = n_rst;
      xfer(1'b1, 1'b0, 4'h1, 12'h03E, d);
      `CHK(lcw, {5'h1F, d[7:0]});
      xfer(1'b1, 1'b0, 4'h1, 12'h000, 16'h00A5);
      push_rx(2);
      `CHK(n_rst - nr, 0);
      xfer(1'b0, 1'b0, 4'h1, 12'h03E, 16'h0000);
      `CHK(pop_r(), 16'h0000);
      `CHK(n_rst - nr, 1);
      xfer(1'b0, 1'b0, 4'h1, 12'h000, 16'h0000);
      `CHK(pop_r(), 16'h0000);
      xfer(1'b0, 1'b0, 4'h1, 12'h020, 16'h0000);
      `CHK(pop_r(), 16'h0000);
      finish_test();
   end
endmodule
`default_nettype wire
